// File: design/psp_port.sv
// parallel slave port with its data/control ports, flags and AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps

// Notes on behaviour
// - select bit set turns the data port into the slave port, else plain I/O
// - outside master accesses with no shared clock, paced by its strobes only
// - select makes control bit 0 read, bit 1 write, bit 2 chip select, all low
// - firmware sets low control-port direction bits to input before slave mode
// - firmware sets analog pin-config low bits so strobe pins are digital
// - select and write low together is a write, taken when first seen
// - select and read low together is a read, taken when first seen
// - master writes land in an 8-bit input word; the master reads the 8-bit data latch
// - input-full flag, control bit 7, set by master write until processor reads
// - overrun flag, bit 5, set on write while input unread; software clears
// - select bit is control bit 4, read/write, resets to zero
// - completed access sets interrupt flag bit 7 of peripheral flags one
// - with external memory bus enabled the slave port and interrupt stay off
module psp_port (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [7:0]  data_pin_in,
	output logic      [7:0]  data_pin_out,
	output logic      [7:0]  data_pin_oe,
	input  wire logic [7:0]  ctrl_pin_in,
	output logic      [7:0]  ctrl_pin_out,
	output logic      [7:0]  ctrl_pin_oe,
	output logic             irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        aw_held;
		logic        aw_ok;
		logic [5:0]  aw_off;
		logic        w_held;
		logic [31:0] w_data;
		logic        w_lane0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [7:0]  control;
		logic [7:0]  dlatch;
		logic [7:0]  ddir;
		logic [7:0]  clatch;
		logic [7:0]  cdir;
		logic [7:0]  flags;
		logic [7:0]  enables;
		logic [7:0]  prios;
		logic [7:0]  analog;
		logic [7:0]  bus_cfg;
		logic [7:0]  inword;
	} psp_state_t;

	psp_state_t            s_reg;
	psp_state_t            s_next;
	logic [15:0]           pins_sync;
	logic [7:0]            dpins;
	logic [7:0]            cpins;
	logic                  psp_active;
	logic                  digital_ok;
	psp_pkg::psp_strobes_t strobes;
	psp_pkg::psp_events_t  ev;
	logic                  wr_fire;
	logic                  rd_fire;
	logic                  wr_lane;
	logic [31:0]           rd_word;
	logic                  rd_ok;
	logic [7:0]            wbyte;

	// ----------------------------------------------------------------
	// pin capture and strobe decode
	// ----------------------------------------------------------------
	// pins belong to the outside master's timing, so all pass two flops
	psp_sync2 #(.W(16)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({ctrl_pin_in, data_pin_in}),
		.sync_out (pins_sync)
	);

	assign dpins = pins_sync[7:0];
	assign cpins = pins_sync[15:8];

	// the external memory bus owns the pins while enabled
	assign psp_active = s_reg.control[psp_pkg::SELECT_BIT]
		&& !s_reg.bus_cfg[psp_pkg::EXT_BUS_BIT];
	// analog-configured strobe pins read as inactive
	assign digital_ok = (s_reg.analog[2:0] == psp_pkg::ALL_DIGITAL);

	always_comb
	begin
		if (psp_active && digital_ok)
		begin
			strobes.cs_n = cpins[psp_pkg::CS_PIN];
			strobes.wr_n = cpins[psp_pkg::WR_PIN];
			strobes.rd_n = cpins[psp_pkg::RD_PIN];
		end
		else
		begin
			strobes = '1;
		end
	end

	psp_strobe_detect u_detect (
		.aclk    (aclk),
		.aresetn (aresetn),
		.strobes (strobes),
		.events  (ev)
	);

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok   = (s_axi_araddr[31:psp_pkg::ADDR_W] == '0);
		case (s_axi_araddr[psp_pkg::ADDR_W-1:0])
			psp_pkg::OFF_CONTROL:     rd_word[7:0] = s_reg.control;
			// slave mode shows the word the master wrote
			psp_pkg::OFF_DPORT_PINS:  rd_word[7:0] = psp_active ? s_reg.inword : dpins;
			psp_pkg::OFF_DPORT_LATCH: rd_word[7:0] = s_reg.dlatch;
			psp_pkg::OFF_DPORT_DIR:   rd_word[7:0] = s_reg.ddir;
			psp_pkg::OFF_CPORT_PINS:  rd_word[7:0] = cpins;
			psp_pkg::OFF_CPORT_LATCH: rd_word[7:0] = s_reg.clatch;
			psp_pkg::OFF_CPORT_DIR:   rd_word[7:0] = s_reg.cdir;
			psp_pkg::OFF_FLAGS_ONE:   rd_word[7:0] = s_reg.flags;
			psp_pkg::OFF_ENABLES_ONE: rd_word[7:0] = s_reg.enables;
			psp_pkg::OFF_PRIOS_ONE:   rd_word[7:0] = s_reg.prios;
			psp_pkg::OFF_ANALOG_CFG:  rd_word[7:0] = s_reg.analog;
			psp_pkg::OFF_BUS_CFG:     rd_word[7:0] = s_reg.bus_cfg;
			default:                  rd_ok = 1'b0;
		endcase
	end

	assign wr_fire = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
	assign rd_fire = s_axi_arvalid && !s_reg.rvalid;
	assign wr_lane = wr_fire && s_reg.aw_ok && s_reg.w_lane0;
	assign wbyte   = s_reg.w_data[7:0];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;

		// bus channels: address and data taken in either order
		if (s_axi_awvalid && !s_reg.aw_held)
		begin
			s_next.aw_held = 1'b1;
			s_next.aw_off  = s_axi_awaddr[psp_pkg::ADDR_W-1:0];
			s_next.aw_ok   = (s_axi_awaddr[31:psp_pkg::ADDR_W] == '0);
		end
		if (s_axi_wvalid && !s_reg.w_held)
		begin
			s_next.w_held  = 1'b1;
			s_next.w_data  = s_axi_wdata;
			s_next.w_lane0 = s_axi_wstrb[0];
		end
		if (s_reg.bvalid && s_axi_bready)
			s_next.bvalid = 1'b0;
		if (s_reg.rvalid && s_axi_rready)
			s_next.rvalid = 1'b0;

		// master read end frees the output word; a processor write below wins
		if (ev.rd_end && psp_active)
			s_next.control[psp_pkg::OUT_FULL_BIT] = 1'b0;

		if (rd_fire)
		begin
			s_next.rvalid = 1'b1;
			s_next.rdata  = rd_word;
			s_next.rresp  = rd_ok ? psp_pkg::RESP_OKAY : psp_pkg::RESP_SLVERR;
			if (rd_ok && psp_active
				&& s_axi_araddr[psp_pkg::ADDR_W-1:0] == psp_pkg::OFF_DPORT_PINS)
				s_next.control[psp_pkg::IN_FULL_BIT] = 1'b0;
		end

		if (wr_fire)
		begin
			s_next.aw_held = 1'b0;
			s_next.w_held  = 1'b0;
			s_next.bvalid  = 1'b1;
			s_next.bresp   = psp_pkg::RESP_SLVERR;
			if (s_reg.aw_ok)
			begin
				s_next.bresp = psp_pkg::RESP_OKAY;
				case (s_reg.aw_off)
					psp_pkg::OFF_CONTROL:     ;
					psp_pkg::OFF_DPORT_PINS:  ;
					psp_pkg::OFF_DPORT_LATCH: ;
					psp_pkg::OFF_DPORT_DIR:   ;
					psp_pkg::OFF_CPORT_PINS:  ;
					psp_pkg::OFF_CPORT_LATCH: ;
					psp_pkg::OFF_CPORT_DIR:   ;
					psp_pkg::OFF_FLAGS_ONE:   ;
					psp_pkg::OFF_ENABLES_ONE: ;
					psp_pkg::OFF_PRIOS_ONE:   ;
					psp_pkg::OFF_ANALOG_CFG:  ;
					psp_pkg::OFF_BUS_CFG:     ;
					default:                  s_next.bresp = psp_pkg::RESP_SLVERR;
				endcase
			end
		end

		// only the low byte lane carries register bits
		if (wr_lane)
		begin
			case (s_reg.aw_off)
				psp_pkg::OFF_CONTROL:
				begin
					s_next.control[psp_pkg::SELECT_BIT] = wbyte[psp_pkg::SELECT_BIT];
					// status bits are read-only; overrun clears on a written zero
					if (!wbyte[psp_pkg::OVERRUN_BIT])
						s_next.control[psp_pkg::OVERRUN_BIT] = 1'b0;
				end
				psp_pkg::OFF_DPORT_PINS, psp_pkg::OFF_DPORT_LATCH:
				begin
					s_next.dlatch = wbyte;
					if (psp_active)
						s_next.control[psp_pkg::OUT_FULL_BIT] = 1'b1;
				end
				psp_pkg::OFF_DPORT_DIR:   s_next.ddir    = wbyte;
				psp_pkg::OFF_CPORT_PINS,
				psp_pkg::OFF_CPORT_LATCH: s_next.clatch  = wbyte;
				psp_pkg::OFF_CPORT_DIR:   s_next.cdir    = wbyte;
				psp_pkg::OFF_FLAGS_ONE:   s_next.flags   = s_reg.flags & ~wbyte;
				psp_pkg::OFF_ENABLES_ONE: s_next.enables = wbyte;
				psp_pkg::OFF_PRIOS_ONE:   s_next.prios   = wbyte;
				psp_pkg::OFF_ANALOG_CFG:  s_next.analog  = wbyte;
				psp_pkg::OFF_BUS_CFG:     s_next.bus_cfg = wbyte;
				default:                  ;
			endcase
		end

		// hardware sets come last so they win over any clear in this cycle
		if (ev.wr_start && psp_active)
		begin
			s_next.inword                    = dpins;
			s_next.control[psp_pkg::IN_FULL_BIT] = 1'b1;
			if (s_reg.control[psp_pkg::IN_FULL_BIT])
				s_next.control[psp_pkg::OVERRUN_BIT] = 1'b1;
		end
		if ((ev.wr_end || ev.rd_end) && psp_active)
			s_next.flags[psp_pkg::IRQ_FLAG_BIT] = 1'b1;
		s_next.flags = s_next.flags & psp_pkg::FLAGS_IMPL;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg         <= '0;
			s_reg.control <= psp_pkg::CONTROL_RST;
			s_reg.dlatch  <= psp_pkg::LATCH_RST;
			s_reg.ddir    <= psp_pkg::DIR_RST;
			s_reg.clatch  <= psp_pkg::LATCH_RST;
			s_reg.cdir    <= psp_pkg::DIR_RST;
			s_reg.flags   <= psp_pkg::FLAGS_RST;
			s_reg.enables <= psp_pkg::ENABLES_RST;
			s_reg.prios   <= psp_pkg::PRIOS_RST;
			s_reg.analog  <= psp_pkg::ANALOG_RST;
			s_reg.bus_cfg <= psp_pkg::BUS_CFG_RST;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = !s_reg.aw_held;
	assign s_axi_wready  = !s_reg.w_held;
	assign s_axi_bvalid  = s_reg.bvalid;
	assign s_axi_bresp   = s_reg.bresp;
	assign s_axi_arready = !s_reg.rvalid;
	assign s_axi_rvalid  = s_reg.rvalid;
	assign s_axi_rdata   = s_reg.rdata;
	assign s_axi_rresp   = s_reg.rresp;

	assign data_pin_out = s_reg.dlatch;
	// slave mode drives only during a master read; the pins lag by the sync depth
	assign data_pin_oe  = psp_active ? {8{ev.rd_active}} : ~s_reg.ddir;
	assign ctrl_pin_out = s_reg.clatch;
	// strobe pins never driven in slave mode, even if firmware left them outputs
	assign ctrl_pin_oe  = ~s_reg.cdir & (psp_active ? ~psp_pkg::STROBE_PINS : 8'hFF);
	assign irq          = |(s_reg.flags & s_reg.enables);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_write_capture: assert property (ev.wr_start && psp_active |=>
		s_reg.control[psp_pkg::IN_FULL_BIT] && s_reg.inword == $past(dpins))
		else $error("master write not captured");
	a_input_full: assert property (s_reg.control[psp_pkg::IN_FULL_BIT] && !rd_fire
		|=> s_reg.control[psp_pkg::IN_FULL_BIT])
		else $error("input full dropped without a processor read");
	a_overrun_set: assert property (ev.wr_start && psp_active
		&& s_reg.control[psp_pkg::IN_FULL_BIT] |=> s_reg.control[psp_pkg::OVERRUN_BIT])
		else $error("overrun not flagged");
	a_read_drive: assert property (psp_active && ev.rd_active |-> data_pin_oe == 8'hFF)
		else $error("data pins not driven during read");
	a_idle_release: assert property (psp_active && !ev.rd_active |-> data_pin_oe == 8'h00)
		else $error("data pins driven outside read");
	a_access_irq: assert property ((ev.wr_end || ev.rd_end) && psp_active
		##1 s_reg.enables[psp_pkg::IRQ_FLAG_BIT] |-> irq)
		else $error("access end did not raise interrupt");
	a_output_full: assert property (wr_lane && psp_active
		&& s_reg.aw_off == psp_pkg::OFF_DPORT_LATCH |=> s_reg.control[psp_pkg::OUT_FULL_BIT])
		else $error("output full not set by latch write");
	a_strobe_input: assert property (psp_active |-> ctrl_pin_oe[2:0] == 3'h0)
		else $error("strobe pin driven in slave mode");
	a_bus_blocks: assert property (s_reg.bus_cfg[psp_pkg::EXT_BUS_BIT]
		|-> !psp_active && !ev.wr_start && !ev.rd_start)
		else $error("slave port active with memory bus on");
	a_write_resp: assert property (wr_fire |=> s_axi_bvalid ##0 s_axi_awready)
		else $error("write response late");

	c_master_write: cover property (ev.wr_start && psp_active);
	c_master_read:  cover property (ev.rd_end && psp_active);
	c_overrun:      cover property ($rose(s_reg.control[psp_pkg::OVERRUN_BIT]));
	c_irq:          cover property ($rose(irq));

endmodule // psp_port

// File: design/psp_pkg.sv
// package: register map, field positions, reset values and carrier types of the slave port
package psp_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 6;
	localparam logic [5:0]  OFF_CONTROL     = 6'h00;
	localparam logic [5:0]  OFF_DPORT_PINS  = 6'h04;
	localparam logic [5:0]  OFF_DPORT_LATCH = 6'h08;
	localparam logic [5:0]  OFF_DPORT_DIR   = 6'h0C;
	localparam logic [5:0]  OFF_CPORT_PINS  = 6'h10;
	localparam logic [5:0]  OFF_CPORT_LATCH = 6'h14;
	localparam logic [5:0]  OFF_CPORT_DIR   = 6'h18;
	localparam logic [5:0]  OFF_FLAGS_ONE   = 6'h1C;
	localparam logic [5:0]  OFF_ENABLES_ONE = 6'h20;
	localparam logic [5:0]  OFF_PRIOS_ONE   = 6'h24;
	localparam logic [5:0]  OFF_ANALOG_CFG  = 6'h28;
	localparam logic [5:0]  OFF_BUS_CFG     = 6'h2C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          IN_FULL_BIT     = 7;
	localparam int          OUT_FULL_BIT    = 6;
	localparam int          OVERRUN_BIT     = 5;
	localparam int          SELECT_BIT      = 4;
	localparam int          IRQ_FLAG_BIT    = 7;
	localparam int          RD_PIN          = 0;
	localparam int          WR_PIN          = 1;
	localparam int          CS_PIN          = 2;
	localparam int          EXT_BUS_BIT     = 0;
	localparam logic [7:0]  STROBE_PINS     = 8'h07;
	localparam logic [2:0]  ALL_DIGITAL     = 3'h7;
	localparam logic [7:0]  FLAGS_IMPL      = 8'h80;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  CONTROL_RST     = 8'h00;
	localparam logic [7:0]  LATCH_RST       = 8'h00;
	localparam logic [7:0]  DIR_RST         = 8'hFF;
	localparam logic [7:0]  FLAGS_RST       = 8'h00;
	localparam logic [7:0]  ENABLES_RST     = 8'h00;
	localparam logic [7:0]  PRIOS_RST       = 8'hFF;
	localparam logic [7:0]  ANALOG_RST      = 8'h00;
	localparam logic [7:0]  BUS_CFG_RST     = 8'h00;

	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic rd_n;
	} psp_strobes_t;

	typedef struct packed {
		logic wr_start;
		logic rd_start;
		logic rd_active;
		logic wr_end;
		logic rd_end;
	} psp_events_t;

endpackage

// File: design/psp_sync2.sv
// two-stage synchroniser for a bus of pin levels
`timescale 1ns/10ps
module psp_sync2 #(
	parameter int W = 8
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} psp_sync_t;

	psp_sync_t s_reg;
	psp_sync_t s_next;

	// first stage feeds only the second stage
	always_comb
	begin
		s_next.meta   = async_in;
		s_next.stable = s_reg.meta;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign sync_out = s_reg.stable;

endmodule // psp_sync2

// File: design/psp_strobe_detect.sv
// turns synchronised select/read/write levels into access start and end pulses
`timescale 1ns/10ps
module psp_strobe_detect (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire psp_pkg::psp_strobes_t strobes,
	output psp_pkg::psp_events_t      events
);

	typedef struct packed {
		logic wr_act;
		logic rd_act;
	} psp_det_t;

	psp_det_t s_reg;
	psp_det_t s_next;
	logic     wr_now;
	logic     rd_now;

	always_comb
	begin
		wr_now        = !strobes.cs_n && !strobes.wr_n;
		rd_now        = !strobes.cs_n && !strobes.rd_n;
		s_next.wr_act = wr_now;
		s_next.rd_act = rd_now;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign events.wr_start  = wr_now && !s_reg.wr_act;
	assign events.rd_start  = rd_now && !s_reg.rd_act;
	assign events.rd_active = rd_now;
	assign events.wr_end    = !wr_now && s_reg.wr_act;
	assign events.rd_end    = !rd_now && s_reg.rd_act;

endmodule // psp_strobe_detect

// File: sim/psp_host_model.sv
// model of the outside microprocessor that drives the slave port strobes and data pins
`timescale 1ns/10ps
module psp_host_model (
	input  wire logic             aclk,
	input  wire logic [7:0]       data_in,
	output logic      [7:0]       data_out,
	output psp_pkg::psp_strobes_t strobes
);
	// ------------------------------------------------------------
	// idle state
	// ------------------------------------------------------------
	// released data lines carry the inverse of the last byte, so a stale copy never passes
	initial
	begin
		strobes = 3'h7;
		data_out = 8'hFF;
	end

	// ------------------------------------------------------------
	// accesses
	// ------------------------------------------------------------
	// read hold counts below 3 would break the pacing that the port needs; writes need only 1
	task automatic host_write(input logic [7:0] d, input int hold);
		@(posedge aclk);
		data_out <= d;
		strobes <= 3'h1;
		repeat (hold) @(posedge aclk);
		strobes <= 3'h7;
		data_out <= ~d;
		repeat (4) @(posedge aclk);
	endtask

	task automatic host_read(output logic [7:0] d, input int hold);
		@(posedge aclk);
		strobes <= 3'h2;
		repeat (hold) @(posedge aclk);
		d = data_in;
		strobes <= 3'h7;
		repeat (4) @(posedge aclk);
	endtask
endmodule // psp_host_model

// File: sim/psp_port_test.sv
// self-checking bench for the slave port: register map, host accesses, flags and interrupt
`timescale 1ns/10ps
module psp_port_test;
	logic                  aclk, aresetn, irq;
	logic [31:0]           awaddr, wdata, araddr, rdata;
	logic                  awvalid, awready, wvalid, wready, bvalid, bready;
	logic                  arvalid, arready, rvalid, rready;
	logic [1:0]            bresp, rresp;
	logic [7:0]            data_pin_in, data_pin_out, data_pin_oe, host_data;
	logic [7:0]            ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe, b1, b2, d;
	logic [4:0]            ctrl_hi;
	psp_pkg::psp_strobes_t host_strobes;
	integer                seed = 32'hf8e921b5;
	int                    err_count = 0;
	int                    checks_done = 0;
	logic [33:0]           rq [$];
	logic [1:0]            bq [$];
	logic [5:0]            roff [10] = '{psp_pkg::OFF_CONTROL, psp_pkg::OFF_DPORT_LATCH,
		psp_pkg::OFF_DPORT_DIR, psp_pkg::OFF_CPORT_LATCH, psp_pkg::OFF_CPORT_DIR,
		psp_pkg::OFF_FLAGS_ONE, psp_pkg::OFF_ENABLES_ONE, psp_pkg::OFF_PRIOS_ONE,
		psp_pkg::OFF_ANALOG_CFG, psp_pkg::OFF_BUS_CFG};
	logic [7:0]            rval [10] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00,
		8'hFF, 8'h00, 8'h00};

	assign data_pin_in = (data_pin_oe & data_pin_out) | (~data_pin_oe & host_data);
	assign ctrl_pin_in = (ctrl_pin_oe & ctrl_pin_out) | (~ctrl_pin_oe & {ctrl_hi, host_strobes});

	always #20 aclk = ~aclk;

	always @(posedge aclk)
		ctrl_hi <= 5'($random(seed));

	psp_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
		.data_pin_oe(data_pin_oe), .ctrl_pin_in(ctrl_pin_in), .ctrl_pin_out(ctrl_pin_out),
		.ctrl_pin_oe(ctrl_pin_oe), .irq(irq));

	psp_host_model host_u (.aclk(aclk), .data_in(data_pin_in), .data_out(host_data),
		.strobes(host_strobes));

	// ------------------------------------------------------------
	// comparison and verdict
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	function automatic logic [33:0] ok(input logic [7:0] b);
		return {26'h0, b};
	endfunction

	// ------------------------------------------------------------
	// bus master
	// ------------------------------------------------------------
	// bready and rready stay high throughout, which the bus allows
	task automatic axi_write(input logic [5:0] a, input logic [7:0] v, input logic [1:0] er,
		input logic hi = 1'b0);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		bq.push_back(er);
		awaddr <= {hi, 25'h0, a};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (awready && !aw_done)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_done)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
	endtask

	task automatic axi_read(input logic [5:0] a, input logic [33:0] e, input logic hi = 1'b0);
		rq.push_back(e);
		araddr <= {hi, 25'h0, a};
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
	endtask

	// ------------------------------------------------------------
	// result watcher
	// ------------------------------------------------------------
	always @(posedge aclk)
	begin
		if (rvalid && rready && rq.size() > 0)
			check("read", {rresp, rdata}, rq.pop_front());
		if (bvalid && bready && bq.size() > 0)
			check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		err_count++;
		$display("mismatch watchdog expected done seen timeout");
		finish_test();
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awaddr, wdata, araddr, awvalid, wvalid, arvalid} = '0;
		bready = 1'b1;
		rready = 1'b1;
		ctrl_hi = 5'h00;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 10; i++)
			axi_read(roff[i], ok(rval[i]));
		axi_read(6'h30, {psp_pkg::RESP_SLVERR, 32'h0});
		axi_read(psp_pkg::OFF_CONTROL, {psp_pkg::RESP_SLVERR, 32'h0}, 1'b1);
		axi_write(6'h30, 8'h55, psp_pkg::RESP_SLVERR);
		$display("test reset done");
		b1 = 8'($random(seed));
		host_u.host_write(b1, 3);
		axi_read(psp_pkg::OFF_CONTROL, ok(8'h00));
		axi_read(psp_pkg::OFF_FLAGS_ONE, ok(8'h00));
		check("data oe", ok(data_pin_oe), 34'h0);
		axi_write(psp_pkg::OFF_CPORT_DIR, 8'hFF, psp_pkg::RESP_OKAY);
		axi_write(psp_pkg::OFF_ENABLES_ONE, 8'h80, psp_pkg::RESP_OKAY);
		axi_write(psp_pkg::OFF_CONTROL, 8'h10, psp_pkg::RESP_OKAY);
		axi_write(psp_pkg::OFF_ANALOG_CFG, 8'h03, psp_pkg::RESP_OKAY);
		host_u.host_write(b1, 3);
		axi_read(psp_pkg::OFF_CONTROL, ok(8'h10));
		axi_write(psp_pkg::OFF_ANALOG_CFG, 8'h07, psp_pkg::RESP_OKAY);
		axi_write(psp_pkg::OFF_BUS_CFG, 8'h01, psp_pkg::RESP_OKAY);
		host_u.host_write(b1, 3);
		axi_read(psp_pkg::OFF_CONTROL, ok(8'h10));
		check("irq", {33'h0, irq}, 34'h0);
		axi_write(psp_pkg::OFF_BUS_CFG, 8'h00, psp_pkg::RESP_OKAY);
		$display("test gating done");
		host_u.host_write(b1, 3);
		axi_read(psp_pkg::OFF_CONTROL, ok(8'h90));
		axi_read(psp_pkg::OFF_FLAGS_ONE, ok(8'h80));
		check("irq", {33'h0, irq}, 34'h1);
		axi_read(psp_pkg::OFF_DPORT_PINS, ok(b1));
		axi_read(psp_pkg::OFF_CONTROL, ok(8'h10));
		b2 = 8'($random(seed));
		host_u.host_write(b2, 8);
		host_u.host_write(b2, 3);
		axi_read(psp_pkg::OFF_CONTROL, ok(8'hB0));
		axi_read(psp_pkg::OFF_DPORT_PINS, ok(b2));
		axi_read(psp_pkg::OFF_CONTROL, ok(8'h30));
		axi_write(psp_pkg::OFF_CONTROL, 8'h10, psp_pkg::RESP_OKAY);
		axi_read(psp_pkg::OFF_CONTROL, ok(8'h10));
		$display("test host write done");
		axi_write(psp_pkg::OFF_FLAGS_ONE, 8'h80, psp_pkg::RESP_OKAY);
		axi_read(psp_pkg::OFF_FLAGS_ONE, ok(8'h00));
		axi_write(psp_pkg::OFF_DPORT_LATCH, b2, psp_pkg::RESP_OKAY);
		axi_read(psp_pkg::OFF_CONTROL, ok(8'h50));
		host_u.host_read(d, 5);
		check("host read", ok(d), ok(b2));
		check("data oe", ok(data_pin_oe), 34'h0);
		axi_read(psp_pkg::OFF_CONTROL, ok(8'h10));
		axi_read(psp_pkg::OFF_FLAGS_ONE, ok(8'h80));
		host_u.host_read(d, 9);
		check("host read", ok(d), ok(b2));
		$display("test host read done");
		axi_write(psp_pkg::OFF_ENABLES_ONE, 8'h00, psp_pkg::RESP_OKAY);
		check("irq", {33'h0, irq}, 34'h0);
		axi_write(psp_pkg::OFF_ENABLES_ONE, 8'h80, psp_pkg::RESP_OKAY);
		check("irq", {33'h0, irq}, 34'h1);
		axi_write(psp_pkg::OFF_FLAGS_ONE, 8'h80, psp_pkg::RESP_OKAY);
		check("irq", {33'h0, irq}, 34'h0);
		axi_write(psp_pkg::OFF_CPORT_DIR, 8'h00, psp_pkg::RESP_OKAY);
		check("ctrl oe", ok(ctrl_pin_oe), ok(8'hF8));
		$display("test interrupt done");
		axi_write(psp_pkg::OFF_CONTROL, 8'h00, psp_pkg::RESP_OKAY);
		axi_write(psp_pkg::OFF_DPORT_DIR, 8'h0F, psp_pkg::RESP_OKAY);
		check("data oe", ok(data_pin_oe), ok(8'hF0));
		// this write also lets the new pin levels pass the synchroniser
		axi_write(psp_pkg::OFF_CPORT_LATCH, b1, psp_pkg::RESP_OKAY);
		check("ctrl out", ok(ctrl_pin_out), ok(b1));
		axi_read(psp_pkg::OFF_DPORT_PINS, ok((8'hF0 & b2) | (8'h0F & ~b2)));
		$display("test plain io done");
		finish_test();
	end
endmodule // psp_port_test
